// ===== dv/error_event_assertions.sv
`default_nettype none
module error_event_assertions
   import error_event_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic [3:0] common_set_mask,
   input wire logic [31:0] common_raw_status [NUM_EVENT_LINES],
   input wire logic [31:0] common_source_mask [NUM_EVENT_LINES],
   input wire link_flags_t link_flags [NUM_LINK_EVENT_LINES],
   input wire logic [1:0] shared_group_a_flag,
   input wire logic [1:0] shared_group_b_flag,
   input wire logic [3:0] event_line
);
   logic wr_q;
   logic rd_q;
   logic [31:0] a_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         a_q <= 32'h0;
      end else begin
         wr_q <= hsel && hready && htrans[1] && hwrite;
         rd_q <= hsel && hready && htrans[1] && !hwrite;
         a_q <= haddr;
      end
   end
   ////////////////////////////////////////
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   chk_clear_ones: assert property (wr_q && a_q == 32'h0 && common_set_mask == 4'h0
      |=> (common_source_mask[0] & $past(hwdata)) == 32'h0) else $error("mask bit not cleared");
   chk_keep_zeros: assert property (wr_q && a_q == 32'h0 && common_set_mask == 4'h0
      |=> (common_source_mask[0] | $past(hwdata)) == ($past(common_source_mask[0]) | $past(hwdata)))
      else $error("mask bit changed by zero");
   chk_other_lines: assert property (wr_q && a_q == 32'h0 && common_set_mask == 4'h0
      |=> $stable(common_source_mask[1]) && $stable(common_source_mask[3]))
      else $error("clear hit another line");
   chk_read_mask: assert property (rd_q && a_q == 32'h4 && $stable(common_source_mask[1])
      |-> hrdata == common_source_mask[1]) else $error("mask read wrong");
   chk_reserved_zero: assert property (((common_source_mask[0] | common_source_mask[2])
      & ~COMMON_MASK_BITS) == 32'h0) else $error("reserved mask bit set");
   chk_line0_event: assert property (event_line[0] ==
      (|link_flags[0] || |(common_raw_status[0] & common_source_mask[0])))
      else $error("event line 0 wrong");
   chk_line1_event: assert property (event_line[1] ==
      (|link_flags[1] || |(common_raw_status[1] & common_source_mask[1])))
      else $error("event line 1 wrong");
   chk_shared_event: assert property (event_line[3] == (shared_group_a_flag[1] ||
      shared_group_b_flag[1] || |(common_raw_status[3] & common_source_mask[3])))
      else $error("event line 3 wrong");
   chk_vector_top: assert property (rd_q && a_q == 32'h18 |-> hrdata[31:3] == 29'h0)
      else $error("shared vector high bits set");
endmodule
bind error_event_mask_and_vector error_event_assertions u_chk (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
   .hready(hready), .hrdata(hrdata), .common_set_mask(common_set_mask),
   .common_raw_status(common_raw_status), .common_source_mask(common_source_mask),
   .link_flags(link_flags), .shared_group_a_flag(shared_group_a_flag),
   .shared_group_b_flag(shared_group_b_flag), .event_line(event_line));
`default_nettype wire

// ===== dv/tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import error_event_pkg::*;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, irq;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, r, d;
   logic [1:0] htrans = '0, sa = '0, sb = '0;
   logic [3:0] csm = '0, event_line;
   logic [31:0] raw [4] = '{default: '0};
   logic [31:0] m [4] = '{default: '0};
   link_flags_t lf [2] = '{default: '0};
   bus_error_t be = '0;
   int n_fail = 0, n_checks = 0, seed = 32'hc7d2, e;
   error_event_mask_and_vector u_error_event_mask_and_vector (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .common_set_mask(csm), .common_raw_status(raw),
      .common_source_mask(), .link_flags(lf), .shared_group_a_flag(sa),
      .shared_group_b_flag(sb), .bus_error_in(be), .event_line(event_line), .irq(irq));
   initial forever #5 hclk = ~hclk;
   // Every register access is short; this span is far beyond the whole run
   initial begin
      #200000;
      n_fail++;
      end_sim();
   end
   ////////////////////////////////////////
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
      n_checks++;
      if (s !== x) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", n, x, s);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   function automatic logic [31:0] vec(input int k);
      logic [31:0] v;
      v = '0;
      if (k < 2) begin
         for (int n = 0; n < 6; n++) begin
            v[2*n] = lf[k].group_a[n];
            v[2*n+1] = lf[k].group_b[n];
         end
         v[12] = |(raw[k] & m[k]);
      end else begin
         v[2:0] = {|(raw[k] & m[k]), sb[k-2], sa[k-2]};
      end
      return v;
   endfunction
   ////////////////////////////////////////
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int k = 0; k < 10; k++) begin
         xfer(1'b0, 8'(4 * k), '0);
         chk("reset value", r, '0);
      end
      // Masks come up disabled, so enable all through the set side first
      hwdata <= '1;
      csm <= 4'hf;
      @(posedge hclk);
      csm <= 4'h0;
      m = '{default: COMMON_MASK_BITS};
      for (int i = 0; i < 24; i++) begin
         e = $random(seed) & 3;
         d = (i == 0) ? '0 : $random(seed) & $random(seed);
         xfer(1'b1, 8'(4 * e), d);
         m[e] &= ~d;
         for (int k = 0; k < 4; k++) begin
            xfer(1'b0, 8'(4 * k), '0);
            chk("mask clear", r, m[k]);
         end
      end
      for (int i = 0; i < 16; i++) begin
         for (int k = 0; k < 4; k++) raw[k] <= (i[0]) ? $random(seed) : '0;
         for (int k = 0; k < 2; k++) lf[k] <= 12'($random(seed) & $random(seed) & $random(seed));
         sa <= 2'($random(seed));
         sb <= 2'($random(seed));
         for (int k = 0; k < 4; k++) begin
            xfer(1'b0, 8'(8'h10 + 4 * k), '0);
            chk("vector", r, vec(k));
            chk("event line", event_line[k], |vec(k));
         end
      end
      raw <= '{default: '0};
      lf <= '{default: '0};
      sa <= 2'h0;
      sb <= 2'h0;
      xfer(1'b1, 8'h28, 32'hf);
      xfer(1'b0, 8'h24, '0);
      @(posedge hclk);
      chk("irq idle", irq, '0);
      for (int i = 0; i < 2; i++) begin
         sa <= 2'h1;
         repeat (3) @(posedge hclk);
         chk("irq", irq, 32'(i == 0));
         xfer(1'b0, 8'h24, '0);
         chk("irq status", r, 32'h4);
         sa <= 2'h0;
         xfer(1'b0, 8'h24, '0);
         chk("irq status cleared", r, '0);
         xfer(1'b1, 8'h28, '0);
      end
      for (int i = 0; i < 3; i++) begin
         d = $random(seed);
         be <= '{1'b1, d[31], d[30] ? CAP_STATUS_DATA : CAP_STATUS_ADDRESS, d[19:16], d[15:0]};
         @(posedge hclk);
         be.valid <= 1'b0;
         xfer(1'b0, 8'h20, '0);
         chk("capture", r, {7'h0, d[31], 1'b0, d[30] ? 3'h4 : 3'h1, d[19:0]});
         xfer(1'b1, 8'h20, $random(seed));
         xfer(1'b0, 8'h20, '0);
         chk("capture cleared", r, '0);
      end
      chk("okay response", {31'h0, hresp}, 32'h0);
      chk("ready", {31'h0, hreadyout}, 32'h1);
      end_sim();
   end
endmodule
`default_nettype wire

// ===== verilog/error_event_mask_and_vector.sv
`default_nettype none
// Operation
// - Writing 1 to a common mask-clear bit clears that mask bit, writing 0 leaves it alone.
// - Reading a common mask-clear register returns the current mask bits.
// - Bits 25..20 mask the six debug-access flags in the listed order.
// - Bits 19..16 mask out-FIFO overflow, memory leak, out-RAM write and in-RAM read.
// - Bits 15..12 mask underflow of inbound packet FIFOs 3..0.
// - Bits 10..8 mask overflow of inbound FIFOs 2..0 and bits 11 and 7..2 read zero.
// - Bits 1 and 0 mask the alignment errors of combiner units 1 and 0.
// - There are four common mask-clear registers, each acting on its own event line only.
// - Each event line has a vector whose bits show a masked status with any active flag.
// - A vector bit stays set while any condition remains in its masked status.
// - Lines 0 and 1 report link n group A at bit 2n, group B at 2n+1, common at 12.
// - Line 1 uses the same layout as line 0 over its own masked status.
// - Lines 2 and 3 report group A at bit 0, group B at bit 1, common at bit 2.
// - The bus error capture register is read-only and a write clears it unless a new error is captured in the same cycle.
// - A captured error records direction, status, byte enables and word address.
module error_event_mask_and_vector
   import error_event_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [3:0] common_set_mask,
   input wire logic [31:0] common_raw_status [NUM_EVENT_LINES],
   output logic [31:0] common_source_mask [NUM_EVENT_LINES],
   input wire link_flags_t link_flags [NUM_LINK_EVENT_LINES],
   input wire logic [1:0] shared_group_a_flag,
   input wire logic [1:0] shared_group_b_flag,
   input wire bus_error_t bus_error_in,
   output logic [NUM_EVENT_LINES-1:0] event_line,
   output logic irq
);
   import error_event_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus slave: zero wait states, always OKAY

   logic wr_pending;
   logic [7:0] wr_addr;
   logic rd_pending;
   logic [7:0] rd_addr;
   logic addr_phase;
   logic [31:0] mask_reg [NUM_EVENT_LINES];
   logic [31:0] vector [NUM_EVENT_LINES];
   logic [31:0] capture;
   logic [3:0] irq_status;
   logic [3:0] irq_mask;
   logic [3:0] prev_event;
   logic [31:0] next_rdata;
   logic status_read;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign addr_phase = hsel && hready && htrans[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pending <= 1'b0;
         rd_pending <= 1'b0;
         wr_addr <= 8'h00;
         rd_addr <= 8'h00;
      end else if (hready) begin
         // Accesses above the register window are ignored, as reads already return zero
         wr_pending <= addr_phase && hwrite && (haddr[31:8] == 24'h000000);
         rd_pending <= addr_phase && !hwrite && (haddr[31:8] == 24'h000000);
         wr_addr <= haddr[7:0];
         rd_addr <= haddr[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Common masks, one per event line

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a[7:2] == ofs[7:2]);
   endfunction

   for (genvar e = 0; e < NUM_EVENT_LINES; e++) begin : g_mask
      localparam logic [7:0] OFS = OFS_MASK_CLEAR_BASE + 8'(e * 4);
      logic clr_hit;
      assign clr_hit = wr_pending && hit(wr_addr, OFS);
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            mask_reg[e] <= COMMON_MASK_RESET;
         end else if (common_set_mask[e]) begin
            // Set from the neighbouring mask-set register wins over a clear
            mask_reg[e] <= (mask_reg[e] | hwdata) & COMMON_MASK_BITS;
         end else if (clr_hit) begin
            mask_reg[e] <= mask_reg[e] & ~hwdata & COMMON_MASK_BITS;
         end
      end
      assign common_source_mask[e] = mask_reg[e];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Vectors; combinational so they follow the masked status directly

   always_comb begin
      logic [31:0] v;
      v = 32'h0000_0000;
      for (int e = 0; e < NUM_EVENT_LINES; e++) begin
         vector[e] = 32'h0000_0000;
      end
      for (int e = 0; e < NUM_LINK_EVENT_LINES; e++) begin
         v = 32'h0000_0000;
         for (int n = 0; n < NUM_LINKS; n++) begin
            v[2*n] = link_flags[e].group_a[n];
            v[2*n+1] = link_flags[e].group_b[n];
         end
         v[VEC_LINKS_COMMON_BIT] = |(common_raw_status[e] & mask_reg[e]);
         vector[e] = v;
      end
      for (int e = NUM_LINK_EVENT_LINES; e < NUM_EVENT_LINES; e++) begin
         v = 32'h0000_0000;
         v[VEC_SHARED_A_BIT] = shared_group_a_flag[e-NUM_LINK_EVENT_LINES];
         v[VEC_SHARED_B_BIT] = shared_group_b_flag[e-NUM_LINK_EVENT_LINES];
         v[VEC_SHARED_COMMON_BIT] = |(common_raw_status[e] & mask_reg[e]);
         vector[e] = v;
      end
   end

   for (genvar e = 0; e < NUM_EVENT_LINES; e++) begin : g_line
      assign event_line[e] = |vector[e];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Bus error capture: latest error held until software writes

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         capture <= CAP_RESET;
      end else if (bus_error_in.valid) begin
         // New capture wins over a clearing write in the same cycle
         capture <= 32'h0000_0000;
         capture[CAP_DIR_BIT] <= bus_error_in.is_read;
         capture[CAP_STATUS_LSB +: 3] <= bus_error_in.status;
         capture[CAP_BYTE_EN_LSB +: 4] <= bus_error_in.byte_en;
         capture[15:0] <= bus_error_in.word_addr;
      end else if (wr_pending && hit(wr_addr, OFS_BUS_ERROR)) begin
         capture <= CAP_RESET;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt: rising event lines set sticky bits, read clears

   assign status_read = rd_pending && hit(rd_addr, OFS_IRQ_STATUS);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prev_event <= 4'h0;
      end else begin
         prev_event <= event_line;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_status <= 4'h0;
      end else begin
         irq_status <= (status_read ? 4'h0 : irq_status) | (event_line & ~prev_event);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_mask <= IRQ_MASK_RESET;
      end else if (wr_pending && hit(wr_addr, OFS_IRQ_MASK)) begin
         irq_mask <= hwdata[3:0];
      end
   end

   assign irq = |(irq_status & irq_mask);

   ////////////////////////////////////////////////////////////////////////////////
   // Read data; registered, unmapped reads return zero

   always_comb begin
      next_rdata = 32'h0000_0000;
      for (int e = 0; e < NUM_EVENT_LINES; e++) begin
         if (hit(haddr[7:0], OFS_MASK_CLEAR_BASE + 8'(e * 4))) begin
            next_rdata = mask_reg[e];
         end
         if (hit(haddr[7:0], OFS_VECTOR_BASE + 8'(e * 4))) begin
            next_rdata = vector[e];
         end
      end
      if (hit(haddr[7:0], OFS_BUS_ERROR)) begin
         next_rdata = capture;
      end
      if (hit(haddr[7:0], OFS_IRQ_STATUS)) begin
         next_rdata = {28'h0000000, irq_status};
      end
      if (hit(haddr[7:0], OFS_IRQ_MASK)) begin
         next_rdata = {28'h0000000, irq_mask};
      end
      if (haddr[31:8] != 24'h000000) begin
         next_rdata = 32'h0000_0000;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_phase && !hwrite) begin
         hrdata <= next_rdata;
      end
   end
endmodule
`default_nettype wire

// ===== verilog/error_event_pkg.sv
`default_nettype none
package error_event_pkg;
   localparam int unsigned NUM_EVENT_LINES = 4;
   localparam int unsigned NUM_LINKS = 6;
   localparam int unsigned NUM_LINK_EVENT_LINES = 2;

   // Register byte offsets
   localparam logic [7:0] OFS_MASK_CLEAR_BASE = 8'h00;
   localparam logic [7:0] OFS_VECTOR_BASE = 8'h10;
   localparam logic [7:0] OFS_BUS_ERROR = 8'h20;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h24;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h28;

   // Common mask layout: implemented bits
   localparam logic [31:0] COMMON_MASK_BITS = 32'h03ff_f703;
   localparam logic [31:0] COMMON_MASK_RESET = 32'h0000_0000;

   // Vector field positions
   localparam int unsigned VEC_LINKS_COMMON_BIT = 12;
   localparam int unsigned VEC_SHARED_A_BIT = 0;
   localparam int unsigned VEC_SHARED_B_BIT = 1;
   localparam int unsigned VEC_SHARED_COMMON_BIT = 2;

   // Capture register field positions
   localparam int unsigned CAP_DIR_BIT = 24;
   localparam int unsigned CAP_STATUS_LSB = 20;
   localparam int unsigned CAP_BYTE_EN_LSB = 16;
   localparam logic [2:0] CAP_STATUS_ADDRESS = 3'h1;
   localparam logic [2:0] CAP_STATUS_DATA = 3'h4;
   localparam logic [31:0] CAP_RESET = 32'h0000_0000;
   localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

   typedef struct packed {
      logic valid;
      logic is_read;
      logic [2:0] status;
      logic [3:0] byte_en;
      logic [15:0] word_addr;
   } bus_error_t;

   typedef struct packed {
      logic [NUM_LINKS-1:0] group_a;
      logic [NUM_LINKS-1:0] group_b;
   } link_flags_t;
endpackage
`default_nettype wire
